// ==== rtl/crcchk_pkg.sv ====
/*
 crcchk_pkg: constants shared by both ends of the checksum block,
 the command port and the small byte buffer.
 assumes one 200 MHz clock and an 8-bit special-register bus.
*/
package crcchk_pkg;
    // checksum model
    localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
    localparam logic [31:0] CRC_PRESET    = 32'hffffffff;
    localparam int          BYTE_W        = 8;
    localparam int          BYTE_MSB      = 7;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam int          IDX_W         = 2;

    // special-register addresses seen by the cpu
    localparam logic [7:0]  SFR_CTRL      = 8'hef;
    localparam logic [7:0]  SFR_INDEX     = 8'hfc;
    localparam logic [7:0]  SFR_DATA      = 8'hfd;
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_PRESET   = 1;

    // program flash geometry
    localparam logic [15:0] FLASH_LAST    = 16'hffff;
    localparam logic [15:0] KB_BYTES      = 16'h0400;
    typedef enum logic [1:0] {
        REGION_NONE = 2'b00,
        REGION_1K   = 2'b01,
        REGION_2K   = 2'b10,
        REGION_ALL  = 2'b11
    } crcchk_region_type;

    // timing
    localparam int          SYS_CLK_NS    = 5;
    localparam int          SCAN_TIME_NS  = 16500000;
    localparam int          SCAN_LIMIT_CYCLES = SCAN_TIME_NS / SYS_CLK_NS;
    localparam int          SCAN_CNT_W    = 22;
    localparam logic [3:0]  NOP_CYCLES    = 4'h8;

    // command port word offsets
    localparam logic [3:0]  AV_CTRL       = 4'h0;
    localparam logic [3:0]  AV_DATA       = 4'h4;
    localparam logic [3:0]  AV_RESULT     = 4'h8;
    localparam logic [3:0]  AV_STATUS     = 4'hc;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_EMPTY    = 1;
    localparam int          STAT_IRQEN    = 2;
    localparam int          STAT_OVERTIME = 3;

    localparam int          FIFO_DEPTH    = 16;
endpackage : crcchk_pkg

// ==== rtl/crcchk_if.sv ====
/*
 crcchk_if: special-register bus between the cpu end and the
 checksum device, plus the cpu hold line.
 assumes both ends run on the same sys_clk.
*/
`timescale 1ns/1ps
interface crcchk_if;
    logic [7:0] sfrAddr;
    logic       sfrWr;
    logic       sfrRd;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic       cpuHold;

    modport device (
        input  sfrAddr,
        input  sfrWr,
        input  sfrRd,
        input  sfrWdata,
        output sfrRdata,
        output cpuHold
    );
    modport cpu (
        output sfrAddr,
        output sfrWr,
        output sfrRd,
        output sfrWdata,
        input  sfrRdata,
        input  cpuHold
    );
endinterface : crcchk_if

// ==== rtl/crcchk_fifo.sv ====
/*
 crcchk_fifo: valid/ready buffer, width and depth set by parameters.
 assumes synchronous push and pop in the sys_clk domain.
*/
`timescale 1ns/1ps
module crcchk_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr, next_wrPtr;
    logic [AW-1:0]    rdPtr, next_rdPtr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push) begin
            next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
        end
        if (pop) begin
            next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage needs no reset; empty flag guards stale words
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule : crcchk_fifo

// ==== rtl/crcchk_device.sv ====
/*
 crcchk_device: checksum engine seen through three special registers
 (control, byte index, data port); byte mode and flash-scan mode.
 assumes the cpu end issues one-cycle strobes and stays off the bus
 while cpuHold is high; the flash answers a flashRead pulse one cycle
 later and keeps flashData until the next pulse.
*/
`timescale 1ns/1ps
module crcchk_device (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    crcchk_if.device                         link,
    output logic [15:0]                      flashAddr,
    output logic                             flashRead,
    input  wire logic [7:0]                  flashData,
    input  wire crcchk_pkg::crcchk_region_type appWriteRegionSize
);
    import crcchk_pkg::*;

    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_BYTE  = 2'b01,
        D_FETCH = 2'b10,
        D_SCAN  = 2'b11
    } crcchk_dstate_type;

    crcchk_dstate_type  state, next_state;
    logic [31:0]        checksumAccumulator, next_checksumAccumulator;
    logic [7:0]         shiftByte, next_shiftByte;
    logic [2:0]         bitCnt, next_bitCnt;
    logic [15:0]        next_flashAddr;
    logic               next_flashRead;
    logic               scanTail, next_scanTail;
    logic [IDX_W-1:0]   resultByteIndex, next_resultByteIndex;
    logic [7:0]         readData, next_readData;
    logic               idle;
    logic               ctrlWr, dataWr, indexWr;
    logic               dataRd, indexRd;
    logic [7:0]         srcByte;
    logic               lastByte;

    // one shift-and-reduce step, message bit taken msb first
    function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
        crc_bit = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : '0);
    endfunction : crc_bit

    // last flash byte that the scan may read
    function automatic logic [15:0] scan_last(input crcchk_region_type r);
        case (r)
            REGION_1K: scan_last = FLASH_LAST - KB_BYTES;
            REGION_2K: scan_last = FLASH_LAST - KB_BYTES - KB_BYTES;
            default:   scan_last = FLASH_LAST;
        endcase
    endfunction : scan_last

    assign idle      = (state == D_IDLE);
    assign link.cpuHold = !idle;
    assign link.sfrRdata = readData;

    // writes are only honoured while idle; the cpu is held otherwise
    assign ctrlWr  = link.sfrWr && idle && (link.sfrAddr == SFR_CTRL);
    assign dataWr  = link.sfrWr && idle && (link.sfrAddr == SFR_DATA);
    assign indexWr = link.sfrWr && idle && (link.sfrAddr == SFR_INDEX);
    assign dataRd  = link.sfrRd && (link.sfrAddr == SFR_DATA);
    assign indexRd = link.sfrRd && (link.sfrAddr == SFR_INDEX);

    // first bit of each scanned byte comes straight off the flash
    assign srcByte  = (bitCnt == '0) ? flashData : shiftByte;
    assign lastByte = (flashAddr == scan_last(appWriteRegionSize));

    // engine group
    always_comb begin
        next_state               = state;
        next_checksumAccumulator = checksumAccumulator;
        next_shiftByte           = shiftByte;
        next_bitCnt              = bitCnt;
        next_flashAddr           = flashAddr;
        next_flashRead           = 1'b0;
        next_scanTail            = scanTail;
        case (state)
            D_IDLE: begin
                if (ctrlWr && link.sfrWdata[CTRL_PRESET]) begin
                    next_checksumAccumulator = CRC_PRESET;
                end
                if (ctrlWr && link.sfrWdata[CTRL_START]) begin
                    next_checksumAccumulator = CRC_PRESET;
                    next_flashAddr           = '0;
                    next_flashRead           = 1'b1;
                    next_bitCnt              = '0;
                    next_scanTail            = 1'b0;
                    next_state               = D_FETCH;
                end else if (dataWr) begin
                    next_shiftByte = link.sfrWdata;
                    next_bitCnt    = '0;
                    next_state     = D_BYTE;
                end
            end
            D_BYTE: begin
                next_checksumAccumulator = crc_bit(checksumAccumulator, shiftByte[BYTE_MSB]);
                next_shiftByte           = {shiftByte[BYTE_MSB-1:0], 1'b0};
                next_bitCnt              = bitCnt + 1'b1;
                if (bitCnt == BIT_LAST) begin
                    next_state = D_IDLE;
                end
            end
            D_FETCH: begin
                next_state = D_SCAN;
            end
            D_SCAN: begin
                next_checksumAccumulator = crc_bit(checksumAccumulator, srcByte[BYTE_MSB]);
                next_shiftByte           = {srcByte[BYTE_MSB-1:0], 1'b0};
                next_bitCnt              = bitCnt + 1'b1;
                // prefetch the next byte so each byte costs eight cycles
                if (bitCnt == '0) begin
                    next_scanTail = lastByte;
                    if (!lastByte) begin
                        next_flashAddr = flashAddr + 1'b1;
                        next_flashRead = 1'b1;
                    end
                end
                if (bitCnt == BIT_LAST && scanTail) begin
                    next_state = D_IDLE;
                end
            end
            default: begin
                next_state = D_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state               <= D_IDLE;
            checksumAccumulator <= CRC_PRESET;
            shiftByte           <= '0;
            bitCnt              <= '0;
            flashAddr           <= '0;
            flashRead           <= 1'b0;
            scanTail            <= 1'b0;
        end else begin
            state               <= next_state;
            checksumAccumulator <= next_checksumAccumulator;
            shiftByte           <= next_shiftByte;
            bitCnt              <= next_bitCnt;
            flashAddr           <= next_flashAddr;
            flashRead           <= next_flashRead;
            scanTail            <= next_scanTail;
        end
    end

    // read-back group: index and data port reads
    always_comb begin
        next_resultByteIndex = resultByteIndex;
        next_readData        = readData;
        if (indexWr) begin
            next_resultByteIndex = link.sfrWdata[IDX_W-1:0];
        end
        if (dataRd) begin
            // reads show the checksum, never the byte last written
            next_readData        = checksumAccumulator[{resultByteIndex, 3'h0} +: BYTE_W];
            next_resultByteIndex = resultByteIndex + 1'b1;
        end else if (indexRd) begin
            next_readData = {{(BYTE_W-IDX_W){1'b0}}, resultByteIndex};
        end else if (link.sfrRd) begin
            next_readData = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resultByteIndex <= '0;
            readData        <= '0;
        end else begin
            resultByteIndex <= next_resultByteIndex;
            readData        <= next_readData;
        end
    end
endmodule : crcchk_device

// ==== rtl/crcchk_host.sv ====
/*
 crcchk_host: cpu end of the checksum block. takes orders over an
 avalon-mm slave port, buffers data bytes, and drives the special
 register bus like a cpu running the usual code sequences.
 assumes the device end answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module crcchk_host #(
    parameter int unsigned SCAN_LIMIT = crcchk_pkg::SCAN_LIMIT_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    crcchk_if.cpu            link,
    input  wire logic [3:0]  avAddress,
    input  wire logic        avWrite,
    input  wire logic        avRead,
    input  wire logic [31:0] avWritedata,
    output logic      [31:0] avReaddata,
    output logic             avWaitrequest,
    output logic             globalIrqEnable
);
    import crcchk_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE   = 3'b000,
        H_RDREQ  = 3'b001,
        H_RDWAIT = 3'b010,
        H_RDCAP  = 3'b011,
        H_SETTLE = 3'b100,
        H_ANSWER = 3'b101
    } crcchk_hstate_type;

    crcchk_hstate_type    state, next_state;
    logic [7:0]           next_sfrAddr, next_sfrWdata;
    logic                 next_sfrWr, next_sfrRd;
    logic [31:0]          next_avReaddata;
    logic [31:0]          result, next_result;
    logic [1:0]           byteCnt, next_byteCnt;
    logic [3:0]           nopCnt, next_nopCnt;
    logic                 pend, next_pend;
    logic                 next_globalIrqEnable;
    logic [SCAN_CNT_W-1:0] busyCnt, next_busyCnt;
    logic                 overtime, next_overtime;
    logic                 isData, fifoInReady, fifoOutValid, fifoPop;
    logic [7:0]           fifoOutData;
    logic                 free;

    assign isData        = avWrite && (avAddress == AV_DATA);
    assign avWaitrequest = isData ? !fifoInReady : (state != H_ANSWER);
    assign free          = (state == H_IDLE) && !link.cpuHold;
    assign fifoPop       = free && fifoOutValid && !(avRead && avAddress == AV_STATUS);

    // bytes queue here; a full buffer stalls the bus master
    crcchk_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) i_crcchk_fifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .inValid  (isData),
        .inReady  (fifoInReady),
        .inData   (avWritedata[7:0]),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    always_comb begin
        next_state           = state;
        next_sfrAddr         = link.sfrAddr;
        next_sfrWdata        = link.sfrWdata;
        next_sfrWr           = 1'b0;
        next_sfrRd           = 1'b0;
        next_avReaddata      = avReaddata;
        next_result          = result;
        next_byteCnt         = byteCnt;
        next_nopCnt          = nopCnt;
        next_pend            = pend;
        next_globalIrqEnable = globalIrqEnable;
        next_busyCnt         = link.cpuHold ? busyCnt + 1'b1 : '0;
        next_overtime        = overtime;
        case (state)
            H_IDLE: begin
                if (avRead && avAddress == AV_STATUS) begin
                    next_avReaddata = '0;
                    next_avReaddata[STAT_BUSY]     = link.cpuHold;
                    next_avReaddata[STAT_EMPTY]    = !fifoOutValid;
                    next_avReaddata[STAT_IRQEN]    = globalIrqEnable;
                    next_avReaddata[STAT_OVERTIME] = overtime;
                    next_state = H_ANSWER;
                end else if (fifoPop) begin
                    next_sfrAddr         = SFR_DATA;
                    next_sfrWdata        = fifoOutData;
                    next_sfrWr           = 1'b1;
                    next_globalIrqEnable = 1'b0;
                    next_pend            = 1'b0;
                    next_nopCnt          = '0;
                    next_state           = H_SETTLE;
                end else if (free && !fifoOutValid && avWrite && avAddress == AV_CTRL) begin
                    next_sfrAddr         = SFR_CTRL;
                    next_sfrWdata        = avWritedata[7:0];
                    next_sfrWr           = 1'b1;
                    next_globalIrqEnable = 1'b0;
                    next_overtime        = 1'b0;
                    next_pend            = 1'b1;
                    next_nopCnt          = '0;
                    next_state           = H_SETTLE;
                end else if (free && !fifoOutValid && avRead && avAddress == AV_RESULT) begin
                    next_sfrAddr  = SFR_INDEX;
                    next_sfrWdata = '0;
                    next_sfrWr    = 1'b1;
                    next_byteCnt  = '0;
                    next_state    = H_RDREQ;
                end else if ((avRead && avAddress != AV_RESULT) ||
                             (avWrite && avAddress != AV_CTRL && !isData)) begin
                    next_avReaddata = '0;
                    next_state      = H_ANSWER;
                end
            end
            H_RDREQ: begin
                next_sfrAddr = SFR_DATA;
                next_sfrRd   = 1'b1;
                next_state   = H_RDWAIT;
            end
            H_RDWAIT: begin
                next_state = H_RDCAP;
            end
            H_RDCAP: begin
                next_result[{byteCnt, 3'h0} +: BYTE_W] = link.sfrRdata;
                next_byteCnt = byteCnt + 1'b1;
                next_state   = H_RDREQ;
                if (byteCnt == 2'h3) begin
                    next_avReaddata = next_result;
                    next_state      = H_ANSWER;
                end
            end
            H_SETTLE: begin
                // eight quiet cycles, then wait out any hold
                if (nopCnt != NOP_CYCLES) begin
                    next_nopCnt = nopCnt + 1'b1;
                end else if (!link.cpuHold) begin
                    next_globalIrqEnable = 1'b1;
                    next_state = pend ? H_ANSWER : H_IDLE;
                end
            end
            H_ANSWER: begin
                next_state = H_IDLE;
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
        // set after the clear so an overrun in the same cycle is kept
        if (busyCnt == SCAN_CNT_W'(SCAN_LIMIT)) begin
            next_overtime = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state           <= H_IDLE;
            link.sfrAddr    <= '0;
            link.sfrWdata   <= '0;
            link.sfrWr      <= 1'b0;
            link.sfrRd      <= 1'b0;
            avReaddata      <= '0;
            result          <= '0;
            byteCnt         <= '0;
            nopCnt          <= '0;
            pend            <= 1'b0;
            globalIrqEnable <= 1'b1;
            busyCnt         <= '0;
            overtime        <= 1'b0;
        end else begin
            state           <= next_state;
            link.sfrAddr    <= next_sfrAddr;
            link.sfrWdata   <= next_sfrWdata;
            link.sfrWr      <= next_sfrWr;
            link.sfrRd      <= next_sfrRd;
            avReaddata      <= next_avReaddata;
            result          <= next_result;
            byteCnt         <= next_byteCnt;
            nopCnt          <= next_nopCnt;
            pend            <= next_pend;
            globalIrqEnable <= next_globalIrqEnable;
            busyCnt         <= next_busyCnt;
            overtime        <= next_overtime;
        end
    end
endmodule : crcchk_host

// ==== verification/crcchk_props.sv ====
/*
 crcchk_props: assertions on the special-register link between the ends.
 assumes it sits beside the crcchk_if instance, all on sys_clk.
*/
`timescale 1ns/1ps
module crcchk_props (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWr,
    input wire logic       sfrRd,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic       cpuHold
);
    import crcchk_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire ctrlWr = sfrWr && sfrAddr == SFR_CTRL;
    wire dataWr = sfrWr && sfrAddr == SFR_DATA && !cpuHold;
    sequence s_byteBusy;
        cpuHold [*8] ##1 !cpuHold;
    endsequence
    property p_byteHold; dataWr |=> s_byteBusy; endproperty
    property p_scanHold; ctrlWr && sfrWdata[CTRL_START] |=> cpuHold [*8]; endproperty
    property p_presetNoHold; ctrlWr && sfrWdata[1:0] == 2'b10 |=> !cpuHold; endproperty
    property p_noStrobeHold; cpuHold |-> !(sfrWr || sfrRd); endproperty
    property p_oneStrobe; !(sfrWr && sfrRd); endproperty
    property p_holdCause;
        $rose(cpuHold) |-> $past(sfrWr) && ($past(sfrAddr) == SFR_DATA || $past(sfrAddr) == SFR_CTRL);
    endproperty
    property p_rdataStable; !sfrRd |=> $stable(sfrRdata); endproperty
    property p_indexNoHold; sfrWr && sfrAddr == SFR_INDEX |=> !cpuHold; endproperty
    a_byteHold: assert property (p_byteHold)
        else $error("byte hold not eight cycles");
    a_scanHold: assert property (p_scanHold)
        else $error("scan start gave no hold");
    a_presetNoHold: assert property (p_presetNoHold)
        else $error("preset alone raised hold");
    a_noStrobeHold: assert property (p_noStrobeHold)
        else $error("strobe while cpu held");
    a_oneStrobe: assert property (p_oneStrobe)
        else $error("read and write strobes together");
    a_holdCause: assert property (p_holdCause)
        else $error("hold rose without a cause");
    a_rdataStable: assert property (p_rdataStable)
        else $error("read data moved without a read");
    a_indexNoHold: assert property (p_indexNoHold)
        else $error("index write raised hold");
endmodule : crcchk_props

// ==== verification/crcchk_bench.sv ====
/*
 crcchk_bench: drives the host's avalon port, host and device joined by
 crcchk_if. assumes a flash answering one cycle after flashRead.
*/
`timescale 1ns/1ps
module crcchk_bench;
    import crcchk_pkg::*;
    logic        sys_clk = 0, sys_rst = 1, avWrite = 0, avRead = 0;
    logic [3:0]  avAddress = 0;
    logic [31:0] avWritedata = 0, avReaddata, rd, model;
    logic        avWaitrequest, globalIrqEnable, flashRead, w;
    logic [15:0] flashAddr;
    logic [7:0]  flashData = 0;
    logic [7:0]  rows [6] = '{8'h00, 8'h01, 8'h80, 8'h7f, 8'hff, 8'h5a};
    int          n_errors = 0, checked = 0, cycles = 0, t0;
    crcchk_if link ();
    crcchk_host #(.SCAN_LIMIT(2000)) i_crcchk_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
        .avAddress(avAddress), .avWrite(avWrite), .avRead(avRead), .avWritedata(avWritedata),
        .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .globalIrqEnable(globalIrqEnable));
    crcchk_device i_crcchk_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .flashAddr(flashAddr),
        .flashRead(flashRead), .flashData(flashData), .appWriteRegionSize(REGION_1K));
    crcchk_props i_crcchk_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfrAddr(link.sfrAddr),
        .sfrWr(link.sfrWr), .sfrRd(link.sfrRd), .sfrWdata(link.sfrWdata), .sfrRdata(link.sfrRdata),
        .cpuHold(link.cpuHold));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // flash content differs per address so a stuck address shows
    always @(posedge sys_clk) if (flashRead) flashData <= flashAddr[7:0] ^ 8'h5a;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            end_of_test();
        end
    end
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
        for (int k = BYTE_MSB; k >= 0; k--) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? CRC_POLY : 32'h0);
        return c;
    endfunction : crc8
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // request rises after an edge, held until waitrequest is seen low at an edge
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avWrite <= wr;
        avRead <= !wr;
        avAddress <= a;
        avWritedata <= d;
        do begin
            @(posedge sys_clk);
            w = avWaitrequest;
            rd = avReaddata;
        end while (w !== 1'b0);
        avWrite <= 0;
        avRead <= 0;
    endtask : av
    task automatic idle;
        @(posedge sys_clk);
    endtask : idle
    task automatic end_of_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 0;
        av(0, AV_STATUS, 0); cmp("status", 32'h6, rd);
        av(0, AV_RESULT, 0); cmp("result", CRC_PRESET, rd);
        av(0, 4'h2, 0); cmp("unmapped", 32'h0, rd);
        av(1, AV_CTRL, 32'h2);
        model = CRC_PRESET;
        foreach (rows[i]) begin
            av(1, AV_DATA, {24'h0, rows[i]});
            model = crc8(model, rows[i]);
            av(0, AV_RESULT, 0); cmp("row", model, rd);
        end
        $display("test byte rows done");
        // twenty back to back bytes fill the 16 deep buffer
        for (int i = 0; i < 20; i++) begin
            av(1, AV_DATA, i);
            model = crc8(model, i[7:0]);
        end
        @(negedge sys_clk);
        while (link.cpuHold !== 1'b1) @(negedge sys_clk);
        cmp("irq off", 32'h0, {31'h0, globalIrqEnable});
        av(0, AV_RESULT, 0); cmp("burst", model, rd);
        av(0, AV_STATUS, 0); cmp("drained", 32'h6, rd);
        idle();
        $display("test burst done");
        avWrite <= 1;
        avAddress <= AV_CTRL;
        avWritedata <= 32'h1;
        while (flashRead !== 1'b1) @(negedge sys_clk);
        cmp("first addr", 32'h0, {16'h0, flashAddr});
        @(negedge sys_clk);
        while (flashRead !== 1'b1) @(negedge sys_clk);
        t0 = cycles;
        cmp("second addr", 32'h1, {16'h0, flashAddr});
        @(negedge sys_clk);
        while (flashRead !== 1'b1) @(negedge sys_clk);
        cmp("third addr", 32'h2, {16'h0, flashAddr});
        cmp("byte period", BYTE_W, cycles - t0);
        cmp("scan irq", 32'h0, {31'h0, globalIrqEnable});
        // full scan is far too long here, so abort it by reset
        @(posedge sys_clk);
        sys_rst <= 1;
        avWrite <= 0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 0;
        av(0, AV_RESULT, 0); cmp("reset result", CRC_PRESET, rd);
        idle();
        $display("test scan abort done");
        end_of_test();
    end
endmodule : crcchk_bench
